// >>> verilog/sps_dev.sv
// Purpose: Device end of the SPI mode serial port with software registers
// Assumes: Software port on clk; one instance per serial port
// Notes:   Slave inputs pass two flops, so slave clocks must be slow
//
// Overview of operation
// - Eight-bit shift register, MSb out, LSb in
// - Output on one clock edge, sample on other
// - Master clocks and presents MSb; slave answers
// - Eight bits swap registers; reload for more
// - Both ends use the same clock polarity
// - Master stops clock and deselects when done
// - Unselected slave ignores bus, drives no data; slave mode without select ignores ss_n and always drives
// - Master selects one slave, one line each
// - Full byte goes to buffer, sets flag
// - Buffer write loads buffer and shift register
// - Shift register reached only through buffer
// - Status low six read-only, control writable except bit 6, which reads zero
// - Reload register sets baud generator rate
// - Each instance fully independent of others
// - Master starts shifting on buffer write
// - Master rate: div4, div16, div64, timer, reload
// - Write while shifting dropped, sets collision flag
// - Buffer full set on receive, cleared on read
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_dev (
  input  logic       clk,
  input  logic       arst_n,
  sps_if.dev         pins,
  input  logic [2:0] addr,
  input  logic [7:0] wdata,
  input  logic       wr,
  input  logic       rd,
  output logic [7:0] rdata,
  input  logic       timer_tick,
  output logic       irq_flag
);
  // All state private to this instance
  sps_pkg::sps_dev_type q;
  sps_pkg::sps_dev_type d;
  logic       master;
  logic       slave_on;
  logic       edge_ev;
  logic       lead;
  logic       tick;
  logic       sample;
  logic       done_ev;
  logic       busy;
  logic [9:0] half;
  logic [7:0] sr_n;

  // Mode decode
  always_comb begin
    master = (q.mode == `SPS_MODE_DIV4) || (q.mode == `SPS_MODE_DIV16)
          || (q.mode == `SPS_MODE_DIV64) || (q.mode == `SPS_MODE_TMR)
          || (q.mode == `SPS_MODE_RELOAD);
    slave_on = (q.mode == `SPS_MODE_SLVSEL) || (q.mode == `SPS_MODE_SLV);
  end

  // Half period of the master clock per rate
  always_comb begin
    case (q.mode)
      `SPS_MODE_DIV16:  half = `SPS_HALF_DIV16;
      `SPS_MODE_DIV64:  half = `SPS_HALF_DIV64;
      `SPS_MODE_RELOAD: half = {1'b0, q.reload, 1'b0} + 10'h002;
      default:          half = `SPS_HALF_DIV4;
    endcase
  end

  // Next state: bus read, engine, then bus write
  always_comb begin
    d       = q;
    edge_ev = 1'b0;
    lead    = 1'b0;
    tick    = 1'b0;
    done_ev = 1'b0;
    d.sel_tail = 1'b0;
    // Pin inputs pass two flops before any use
    d.sck_m = pins.sck;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.sdi_m = pins.dev_sdi;
    d.sdi_s = q.sdi_m;
    d.ss_m  = pins.ss_n;
    d.ss_s  = q.ss_m;

    // Read data valid the cycle after the strobe
    if (rd) begin
      case (addr)
        `SPS_IDX_STAT:   d.rdata = {q.smp, q.cke, 5'h00, q.bf};
        `SPS_IDX_CON1:   d.rdata = {q.write_collision_flag, 1'b0, q.en, q.ckp, q.mode};
        `SPS_IDX_CON3:   d.rdata = {7'h00, q.hold};
        `SPS_IDX_BUF:    d.rdata = q.rbuf;
        `SPS_IDX_RELOAD: d.rdata = q.reload;
        `SPS_IDX_IRQ:    d.rdata = {7'h00, q.irq};
        default:         d.rdata = 8'h00;
      endcase
      if (addr == `SPS_IDX_BUF) begin
        d.bf = 1'b0;
      end
    end

    // Serial engine
    if (!q.en) begin
      d.eng   = sps_pkg::eng_idle;
      d.edges = 4'h0;
      d.div   = 10'h000;
      d.sclk  = q.ckp;
    end else if (master) begin
      if (q.eng == sps_pkg::eng_run) begin
        if (q.mode == `SPS_MODE_TMR) begin
          tick = timer_tick;
        end else begin
          tick = (q.div == half - 10'h001);
        end
        d.div = tick ? 10'h000 : q.div + 10'h001;
        if (tick) begin
          edge_ev = 1'b1;
          lead    = (q.sclk == q.ckp);
          d.sclk  = ~q.sclk;
        end
      end else begin
        d.sclk = q.ckp;
      end
    end else if (slave_on) begin
      if (q.mode == `SPS_MODE_SLVSEL && q.ss_s) begin
        d.edges = 4'h0;
        d.eng   = sps_pkg::eng_idle;
      end else if (q.sck_s != q.sck_p) begin
        edge_ev = 1'b1;
        lead    = (q.sck_s != q.ckp);
        d.eng   = sps_pkg::eng_run;
      end
    end
    // Clock edge setting picks which edge samples
    sample = edge_ev & (lead == q.cke);
    sr_n   = sample ? {q.sr[6:0], q.sdi_s} : q.sr;
    if (edge_ev) begin
      d.sr    = sr_n;
      d.edges = q.edges + 4'h1;
      if (!sample) begin
        d.dout = q.sr[7];
      end
      if (q.edges == `SPS_LAST_EDGE) begin
        done_ev = 1'b1;
        d.edges = 4'h0;
        d.eng   = sps_pkg::eng_idle;
        d.rbuf  = sr_n;
        d.bf    = 1'b1;
        d.irq   = 1'b1;
        // Select stays low one more clock: a synchronising slave sees
        // the last edge and the deselect in the same cycle otherwise
        d.sel_tail = master;
      end
    end

    // Register writes; hardware sets win over software clears
    busy = (q.eng == sps_pkg::eng_run) || edge_ev;
    if (wr) begin
      case (addr)
        `SPS_IDX_STAT: begin
          d.smp = wdata[`SPS_STAT_SMP];
          d.cke = wdata[`SPS_STAT_CKE];
        end
        `SPS_IDX_CON1: begin
          d.write_collision_flag = wdata[`SPS_CON1_WRITE_COLLISION_FLAG];
          d.en   = wdata[`SPS_CON1_EN];
          d.ckp  = wdata[`SPS_CON1_CKP];
          d.mode = wdata[`SPS_CON1_MODE];
        end
        `SPS_IDX_CON3: d.hold = wdata[`SPS_CON3_HOLD];
        `SPS_IDX_RELOAD: d.reload = wdata;
        `SPS_IDX_IRQ: d.irq = (q.irq & wdata[`SPS_IRQ_FLAG]) | done_ev;
        `SPS_IDX_BUF: begin
          if (q.en && busy) begin
            d.write_collision_flag = 1'b1;
          end else if (!q.write_collision_flag) begin
            d.rbuf = wdata;
            d.sr   = wdata;
            d.dout = wdata[7];
            if (q.en && master) begin
              d.eng   = sps_pkg::eng_run;
              d.div   = 10'h000;
              d.edges = 4'h0;
            end
          end
        end
        default: d.rdata = d.rdata;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata            = q.rdata;
  assign irq_flag         = q.irq;
  assign pins.dev_sck_o   = q.sclk;
  assign pins.dev_sck_oe  = q.en & master;
  assign pins.dev_sdo_o   = q.dout;
  // In select mode a deselected slave floats its data line; the slave without select always drives it
  assign pins.dev_sdo_oe  = q.en & (master | (q.mode == `SPS_MODE_SLV)
                          | ((q.mode == `SPS_MODE_SLVSEL) & ~q.ss_s));
  // One select line: asserted during a byte or while held
  assign pins.dev_ss_n_o  = ~((q.eng == sps_pkg::eng_run) | q.sel_tail
                          | q.hold);
  assign pins.dev_ss_n_oe = q.en & master;
endmodule // sps_dev

// >>> verilog/sps_params.svh
// Purpose: Offsets, field positions, codes and counts of the serial port
// Assumes: Included by its bare name from both ends
// Notes:   Registers index the plain software port, one byte each
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
// Register indices on the software port
`define SPS_IDX_STAT    3'h0
`define SPS_IDX_CON1    3'h1
`define SPS_IDX_CON3    3'h2
`define SPS_IDX_BUF     3'h3
`define SPS_IDX_RELOAD  3'h4
`define SPS_IDX_IRQ     3'h5
// Field positions
`define SPS_STAT_SMP    7
`define SPS_STAT_CKE    6
`define SPS_STAT_BF     0
`define SPS_CON1_WRITE_COLLISION_FLAG   7
`define SPS_CON1_EN     5
`define SPS_CON1_CKP    4
`define SPS_CON1_MODE   3:0
`define SPS_CON3_HOLD   0
`define SPS_IRQ_FLAG    0
// Reset value of every register
`define SPS_RST_REG     8'h00
// Mode codes of the mode field
`define SPS_MODE_DIV4   4'h0
`define SPS_MODE_DIV16  4'h1
`define SPS_MODE_DIV64  4'h2
`define SPS_MODE_TMR    4'h3
`define SPS_MODE_SLVSEL 4'h4
`define SPS_MODE_SLV    4'h5
`define SPS_MODE_RELOAD 4'ha
// Half serial clock periods in system clocks
`define SPS_HALF_DIV4   10'h002
`define SPS_HALF_DIV16  10'h008
`define SPS_HALF_DIV64  10'h020
// Serial clock edges in one byte, counted from zero
`define SPS_LAST_EDGE   4'hf
`endif

// >>> verilog/sps_pkg.sv
// Purpose: Types shared by both ends of the serial link
// Assumes: Nothing
// Notes:   Each end keeps its whole state in one packed struct
package sps_pkg;
  typedef enum logic [0:0] {eng_idle, eng_run} sps_eng_type;

  typedef struct packed {
    logic        smp;
    logic        cke;
    logic        write_collision_flag;
    logic        en;
    logic        ckp;
    logic [3:0]  mode;
    logic        hold;
    logic [7:0]  rbuf;
    logic        bf;
    logic        irq;
    logic [7:0]  reload;
    logic [7:0]  rdata;
    logic [7:0]  sr;
    logic        dout;
    logic [3:0]  edges;
    logic [9:0]  div;
    logic        sclk;
    sps_eng_type eng;
    logic        sel_tail;
    logic        sck_m;
    logic        sck_s;
    logic        sck_p;
    logic        sdi_m;
    logic        sdi_s;
    logic        ss_m;
    logic        ss_s;
  } sps_dev_type;

  typedef struct packed {
    logic [7:0]  sr;
    logic        dout;
    logic [3:0]  edges;
    logic [9:0]  div;
    logic        sclk;
    sps_eng_type eng;
    logic [7:0]  rx;
    logic        done;
    logic        sck_m;
    logic        sck_s;
    logic        sck_p;
    logic        sdi_m;
    logic        sdi_s;
    logic        ss_m;
    logic        ss_s;
  } sps_far_type;
endpackage

// >>> verilog/sps_if.sv
// Purpose: Wires of the serial link between the device and the far end
// Assumes: Each driver gives a level and an enable
// Notes:   Undriven clock reads low, undriven data and select read high
`timescale 1ns/10ps
interface sps_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_sdo_o;
  logic dev_sdo_oe;
  logic dev_ss_n_o;
  logic dev_ss_n_oe;
  logic far_sck_o;
  logic far_sck_oe;
  logic far_sdo_o;
  logic far_sdo_oe;
  logic far_ss_n_o;
  logic far_ss_n_oe;
  logic sck;
  logic ss_n;
  logic dev_sdi;
  logic far_sdi;

  // Resolve shared lines; pulls stand in for absent drivers
  assign sck     = dev_sck_oe ? dev_sck_o
                 : (far_sck_oe ? far_sck_o : 1'b0);
  assign ss_n    = dev_ss_n_oe ? dev_ss_n_o
                 : (far_ss_n_oe ? far_ss_n_o : 1'b1);
  assign dev_sdi = far_sdo_oe ? far_sdo_o : 1'b1;
  assign far_sdi = dev_sdo_oe ? dev_sdo_o : 1'b1;

  modport dev (output dev_sck_o, dev_sck_oe, dev_sdo_o, dev_sdo_oe,
               output dev_ss_n_o, dev_ss_n_oe,
               input  sck, ss_n, dev_sdi);
  modport far (output far_sck_o, far_sck_oe, far_sdo_o, far_sdo_oe,
               output far_ss_n_o, far_ss_n_oe,
               input  sck, ss_n, far_sdi);
endinterface

// >>> verilog/sps_far.sv
// Purpose: Far end of the link, a plain SPI master or slave
// Assumes: Start is a one-cycle pulse from same-clock user logic
// Notes:   Slave edges arrive three clocks late through the synchroniser
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_far #(
  parameter logic [9:0] HALF_CYC = 10'h008
) (
  input  logic       clk,
  input  logic       arst_n,
  sps_if.far         pins,
  input  logic       is_master,
  input  logic       cpol,
  input  logic       cke,
  input  logic       hold_sel,
  input  logic       start,
  input  logic [7:0] tx_byte,
  output logic       busy,
  output logic [7:0] rx_byte,
  output logic       rx_done
);
  sps_pkg::sps_far_type q;
  sps_pkg::sps_far_type d;
  logic       edge_ev;
  logic       lead;
  logic       sample;
  logic [7:0] sr_n;

  // Next state of the whole end
  always_comb begin
    d       = q;
    edge_ev = 1'b0;
    lead    = 1'b0;
    d.done  = 1'b0;
    // Two flops on each pin before use
    d.sck_m = pins.sck;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.sdi_m = pins.far_sdi;
    d.sdi_s = q.sdi_m;
    d.ss_m  = pins.ss_n;
    d.ss_s  = q.ss_m;
    if (is_master) begin
      if (q.eng == sps_pkg::eng_run) begin
        d.div = q.div + 10'h001;
        if (q.div == HALF_CYC - 10'h001) begin
          d.div   = 10'h000;
          edge_ev = 1'b1;
          lead    = (q.sclk == cpol);
          d.sclk  = ~q.sclk;
        end
      end else begin
        d.sclk = cpol;
      end
    end else if (q.ss_s) begin
      d.edges = 4'h0;
      d.eng   = sps_pkg::eng_idle;
    end else if (q.sck_s != q.sck_p) begin
      edge_ev = 1'b1;
      lead    = (q.sck_s != cpol);
      d.eng   = sps_pkg::eng_run;
    end
    // Sample on one edge, present on the other
    sample = edge_ev & (lead == cke);
    sr_n   = sample ? {q.sr[6:0], q.sdi_s} : q.sr;
    if (edge_ev) begin
      d.sr    = sr_n;
      d.edges = q.edges + 4'h1;
      if (!sample) begin
        d.dout = q.sr[7];
      end
      if (q.edges == `SPS_LAST_EDGE) begin
        d.edges = 4'h0;
        d.eng   = sps_pkg::eng_idle;
        d.rx    = sr_n;
        d.done  = 1'b1;
      end
    end
    // Reload only between bytes
    if (start && q.eng == sps_pkg::eng_idle && !edge_ev) begin
      d.sr   = tx_byte;
      d.dout = tx_byte[7];
      d.div  = 10'h000;
      if (is_master) begin
        d.eng = sps_pkg::eng_run;
      end
    end
  end

  // Single state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy             = (q.eng == sps_pkg::eng_run);
  assign rx_byte          = q.rx;
  assign rx_done          = q.done;
  assign pins.far_sck_o   = q.sclk;
  assign pins.far_sck_oe  = is_master;
  assign pins.far_sdo_o   = q.dout;
  assign pins.far_sdo_oe  = is_master | ~q.ss_s;
  // One select line only; held one clock past the last edge so a
  // synchronising slave still counts that edge
  assign pins.far_ss_n_o  = ~(busy | q.done | hold_sel);
  assign pins.far_ss_n_oe = is_master;
endmodule // sps_far

// >>> testbench/sps_checker.sv
// Purpose: Assertions on the shared wires of the serial link
// Assumes: Idle clock level is not changed inside a frame
// Notes:   Counts clock edges per frame from the wires alone
`timescale 1ns/10ps
module sps_checker (
  input logic clk,
  input logic arst_n,
  input logic sck,
  input logic ss_n,
  input logic dev_sck_o,
  input logic dev_sck_oe,
  input logic dev_sdo_o,
  input logic dev_sdo_oe,
  input logic dev_ss_n_o,
  input logic dev_ss_n_oe,
  input logic far_sck_oe,
  input logic far_sdo_oe,
  input logic far_ss_n_oe
);
  typedef struct packed {
    logic [5:0] edges;
    logic       sck;
    logic       idle;
  } sps_chk_type;
  sps_chk_type hlp_q;
  sps_chk_type hlp_d;

  // Edges per frame; idle level follows the clock while deselected
  always_comb begin
    hlp_d     = hlp_q;
    hlp_d.sck = sck;
    if (ss_n) begin
      hlp_d.edges = 6'h00;
      hlp_d.idle  = sck;
    end else if (sck != hlp_q.sck) begin
      hlp_d.edges = hlp_q.edges + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hlp_q <= '0;
    end else begin
      hlp_q <= hlp_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  one_master_a: assert property (!(dev_sck_oe && far_sck_oe))
    else $error("two clock drivers");
  one_select_a: assert property (!(dev_ss_n_oe && far_ss_n_oe))
    else $error("two select drivers");
  frame_edges_a: assert property ($rose(ss_n) |->
    hlp_q.edges[3:0] == 4'h0 && hlp_q.edges != 6'h00)
    else $error("frame not whole bytes");
  idle_level_a: assert property ($rose(ss_n) |-> sck == hlp_q.idle)
    else $error("clock not idle at frame end");
  first_edge_a: assert property ($fell(ss_n) |->
    ##[1:80] $changed(sck))
    else $error("no clock after select");
  idle_sck_a: assert property (dev_sck_oe && $past(dev_sck_oe) &&
    $changed(dev_sck_o) |-> !dev_ss_n_o)
    else $error("clock moves while deselected");
  dev_quiet_a: assert property ((far_sck_oe && ss_n) [*6] |->
    !dev_sdo_oe)
    else $error("unselected device drives data");
  far_quiet_a: assert property ((!far_sck_oe && ss_n) [*6] |->
    !far_sdo_oe)
    else $error("unselected far end drives data");
  sdo_edge_a: assert property (dev_sck_oe && !dev_ss_n_o &&
    !$past(dev_ss_n_o) && $changed(dev_sdo_o) |-> $changed(dev_sck_o))
    else $error("data moved off the output edge");

  cover property ($rose(ss_n) && hlp_q.edges == 6'h10);
  cover property ($fell(ss_n) && dev_sck_oe);
  cover property ($fell(ss_n) && far_sck_oe);
endmodule // sps_checker

// >>> testbench/tb_top.sv
// Purpose: Byte exchanges in both roles plus register checks
// Assumes: Far slave keeps up only at a half period of six clocks or more
// Notes:   Div4 and a second port instance are not exercised
`timescale 1ns/10ps
`include "sps_params.svh"
module tb_top;
  logic       clk, arst_n, wr, rd, tmr, is_m, cpol, cke, start;
  logic       busy, rx_done, irq;
  logic [2:0] addr, tcnt;
  logic [7:0] wdata, rdata, tx, rx;
  int         err_total, checks;

  sps_if sps_if_inst ();
  sps_dev sps_dev_inst (.clk(clk), .arst_n(arst_n),
    .pins(sps_if_inst.dev), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_tick(tmr), .irq_flag(irq));
  sps_far sps_far_inst (.clk(clk), .arst_n(arst_n),
    .pins(sps_if_inst.far), .is_master(is_m), .cpol(cpol), .cke(cke),
    .hold_sel(1'b0), .start(start), .tx_byte(tx), .busy(busy),
    .rx_byte(rx), .rx_done(rx_done));
  sps_checker sps_checker_inst (.clk(clk), .arst_n(arst_n),
    .sck(sps_if_inst.sck), .ss_n(sps_if_inst.ss_n),
    .dev_sck_o(sps_if_inst.dev_sck_o),
    .dev_sck_oe(sps_if_inst.dev_sck_oe),
    .dev_sdo_o(sps_if_inst.dev_sdo_o),
    .dev_sdo_oe(sps_if_inst.dev_sdo_oe),
    .dev_ss_n_o(sps_if_inst.dev_ss_n_o),
    .dev_ss_n_oe(sps_if_inst.dev_ss_n_oe),
    .far_sck_oe(sps_if_inst.far_sck_oe),
    .far_sdo_oe(sps_if_inst.far_sdo_oe),
    .far_ss_n_oe(sps_if_inst.far_ss_n_oe));

  // Timer pulse every eighth cycle; a synchronising far slave needs a
  // half period of six clocks or more to answer in time
  always #25 clk = ~clk;
  always @(posedge clk) begin
    tcnt <= tcnt + 3'h1;
    tmr  <= (tcnt == 3'h7);
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask

  task automatic wreg(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is valid from the cycle after the strobe and holds until the next read
  task automatic rreg(logic [2:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg%0d", a), {8'h00, rdata}, {8'h00, e});
  endtask

  // Counts cycles with select low; a hang ends the run
  task automatic wait_irq(output int lo);
    int n;
    lo = 0;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) begin
      @(posedge clk);
      #1 lo += (sps_if_inst.ss_n === 1'b0);
    end
    if (n == 3000) begin
      err_total++;
      $display("BAD irq_flag exp 1 saw %b", irq);
      final_report();
    end
  endtask

  task automatic regs();
    int i;
    for (i = 0; i < 8; i++) rreg(i[2:0], 8'h00);
    wreg(3'h0, 8'hff);
    rreg(3'h0, 8'hc0);
    wreg(3'h1, 8'h1f);
    rreg(3'h1, 8'h1f);
    wreg(3'h6, 8'h55);
    rreg(3'h6, 8'h00);
    wreg(3'h0, 8'h00);
    wreg(3'h1, 8'h00);
    wreg(3'h3, 8'h77);
    repeat (40) @(posedge clk);
    #1 chk("sel", {15'h0, sps_if_inst.ss_n}, 16'h0001);
    rreg(3'h3, 8'h77);
    rreg(3'h5, 8'h00);
  endtask

  // Device master against far slave; col adds a write while busy
  task automatic xfer_m(logic [3:0] m, logic k, logic [15:0] e, logic col);
    int         lo;
    logic [7:0] a;
    a = 8'h96 ^ {m, m};
    cke <= k;
    wreg(3'h0, {1'b0, k, 6'h00});
    wreg(3'h1, {4'h2, m});
    @(posedge clk);
    tx    <= ~a;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wreg(3'h3, a);
    if (col) wreg(3'h3, 8'hff);
    if (col) rreg(3'h1, {4'ha, m});
    wait_irq(lo);
    if (e != 16'h0) chk("frame", lo[15:0], e);
    rreg(3'h0, {1'b0, k, 6'h01});
    rreg(3'h3, ~a);
    rreg(3'h0, {1'b0, k, 6'h00});
    chk("far_rx", {8'h00, rx}, {8'h00, a});
    rreg(3'h5, 8'h01);
    wreg(3'h5, 8'h00);
    if (col) wreg(3'h1, {4'h2, m});
  endtask

  // Far master with idle-high clock against device slave
  task automatic xfer_s();
    int lo;
    wreg(3'h0, 8'h00);
    wreg(3'h1, {4'h3, `SPS_MODE_SLVSEL});
    // Far clock settles at its idle level before select falls
    cke  <= 1'b0;
    cpol <= 1'b1;
    is_m <= 1'b1;
    wreg(3'h3, 8'hc3);
    @(posedge clk);
    tx    <= 8'h5e;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1 chk("far_busy", {15'h0, busy}, 16'h0001);
    wait_irq(lo);
    chk("far_idle", {15'h0, busy}, 16'h0000);
    chk("far_rx", {8'h00, rx}, 16'h00c3);
    // Status first: reading the buffer clears the full flag
    rreg(3'h0, 8'h01);
    rreg(3'h3, 8'h5e);
  endtask

  initial begin
    clk = 0; arst_n = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
    tmr = 0; tcnt = 0; is_m = 0; cpol = 0; cke = 0; start = 0;
    tx = 0; err_total = 0; checks = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    regs();
    wreg(3'h4, 8'h02);
    rreg(3'h4, 8'h02);
    xfer_m(`SPS_MODE_DIV16, 1'b1, 16'h0080, 1'b0);
    xfer_m(`SPS_MODE_DIV64, 1'b0, 16'h0200, 1'b0);
    xfer_m(`SPS_MODE_RELOAD, 1'b1, 16'h0060, 1'b0);
    xfer_m(`SPS_MODE_TMR, 1'b0, 16'h0000, 1'b1);
    xfer_s();
    final_report();
  end
endmodule // tb_top
